// >>> src/scp_defines.svh
// Constants of the serial configuration port: word layout, control bits, reset values.
// Summary of operation
// R1: Shift bits only while select is low.
// R2: Sample data on each rising shift edge.
// R3: Load the addressed register every 24th edge.
// R4: Discard a trailing partial group of bits.
// R5: Edge counter restarts at select fall, counts 24s.
// R6: Word is 8 address bits, 16 data bits.
// R7: Work from fast shift clocks down to hertz.
// R8: Host writes zero into unused data bits.
// R9: Host sets readback enable before any read.
// R10: Readback drives the addressed register's 16 bits.
// R11: Update readback bits after falling shift edges.
// R12: Host captures readback on rise or next fall.
// R13: Readback mode still accepts control register writes.
// R14: Readback enable set turns cycles into reads.
// R15: Output driver off unless readback is enabled.
// R16: Soft reset bit clears everything, self clears.
// R17: All registers reset to zero.
// R18: Bits travel most significant first.
// R19: Select rising mid-word resets the edge counter.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

`define SCP_WORD_BITS 24
`define SCP_ADDR_BITS 8
`define SCP_DATA_BITS 16
`define SCP_REG_COUNT 256
`define SCP_COUNT_LAST 5'h17
`define SCP_COUNT_ADDR_LAST 5'h07
`define SCP_COUNT_DATA_FIRST 5'h08
`define SCP_REG_CTRL 8'h00
`define SCP_CTRL_SOFT_RESET 0
`define SCP_CTRL_READBACK 1
`define SCP_RESET_VALUE 16'h0000

`endif

// >>> src/scp_pkg.sv
// Types shared by the serial configuration port and its register store.
package scp_pkg;

	typedef logic [7:0] scp_addr_t;
	typedef logic [15:0] scp_data_t;
	typedef logic [4:0] scp_count_t;
	typedef logic [22:0] scp_shift_t;

	typedef enum logic [0:0] {
		SCP_IDLE = 1'b0,
		SCP_SHIFT = 1'b1
	} scp_state_e;

endpackage

// >>> src/scp_regfile.sv
// Register store of the configuration port with per-entry valid bits and registered read data.
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_regfile import scp_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic wr_en,
	input wire scp_addr_t wr_addr,
	input wire scp_data_t wr_data,
	input wire scp_addr_t rd_addr,
	output scp_data_t rd_data
);

	scp_data_t mem [0:`SCP_REG_COUNT-1];
	logic [`SCP_REG_COUNT-1:0] valid;
	logic [`SCP_REG_COUNT-1:0] next_valid;
	scp_data_t next_rd_data;

	// An entry never written since the last clear reads as its reset value.
	genvar i;
	generate
		for (i = 0; i < `SCP_REG_COUNT; i++) begin : g_valid
			always_comb begin
				if (clear) begin
					next_valid[i] = 1'b0; // [R16] [R17]
				end else if (wr_en && wr_addr == 8'(i)) begin
					next_valid[i] = 1'b1;
				end else begin
					next_valid[i] = valid[i];
				end
			end
		end
	endgenerate

	always_comb begin
		if (valid[rd_addr]) begin
			next_rd_data = mem[rd_addr];
		end else begin
			next_rd_data = `SCP_RESET_VALUE; // [R17]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			valid <= '0;
			rd_data <= `SCP_RESET_VALUE;
		end else begin
			valid <= next_valid;
			rd_data <= next_rd_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

endmodule

// >>> src/scp_port.sv
// Serial configuration port: samples the host's select, shift clock and data, loads registers
// and returns register contents in readback mode.
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_port import scp_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hw_reset,
	input wire logic port_select_n,
	input wire logic shift_clk,
	input wire logic shift_data_in,
	output logic shift_data_out,
	output logic shift_data_out_oe_n,
	output logic readback_enabled,
	output logic cfg_wr_valid,
	output scp_addr_t cfg_wr_addr,
	output scp_data_t cfg_wr_data
);

	// Pin synchronisers. Only the second stage and later are read by logic.
	logic sel_meta;
	logic sel_sync;
	logic sclk_meta;
	logic sclk_sync;
	logic sclk_prev;
	logic sdi_meta;
	logic sdi_sync;
	logic rst_meta;
	logic rst_sync;

	// Word assembly state.
	scp_state_e state;
	scp_state_e next_state;
	scp_count_t count;
	scp_count_t next_count;
	scp_shift_t shift;
	scp_shift_t next_shift;

	// Control and readback state.
	logic next_readback_enabled;
	logic rd_pending;
	logic next_rd_pending;
	scp_data_t out_shift;
	scp_data_t next_out_shift;
	logic next_shift_data_out;
	logic next_shift_data_out_oe_n;
	logic next_cfg_wr_valid;
	scp_addr_t next_cfg_wr_addr;
	scp_data_t next_cfg_wr_data;

	// Register store access, driven combinationally from this clock domain.
	logic mem_clear;
	logic mem_wr_en;
	scp_addr_t mem_wr_addr;
	scp_data_t mem_wr_data;
	scp_addr_t mem_rd_addr;
	scp_data_t mem_rd_data;

	// Decoded edges and the word just completed.
	logic sclk_rise;
	logic sclk_fall;
	logic word_done;
	scp_addr_t word_addr;
	scp_data_t word_data;

	scp_regfile u_regfile (
		.core_clk(core_clk),
		.resetn(resetn),
		.clear(mem_clear),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.rd_addr(mem_rd_addr),
		.rd_data(mem_rd_data)
	);

	// The host's pins belong to no clock of ours; each passes two flops first.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sel_meta <= 1'b1;
			sel_sync <= 1'b1;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_prev <= 1'b0;
			sdi_meta <= 1'b0;
			sdi_sync <= 1'b0;
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			sel_meta <= port_select_n;
			sel_sync <= sel_meta;
			sclk_meta <= shift_clk;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
			sdi_meta <= shift_data_in;
			sdi_sync <= sdi_meta;
			rst_meta <= hw_reset;
			rst_sync <= rst_meta;
		end
	end

	// Edges are found by sampling, so any duty cycle and any slow rate is accepted; the shift
	// clock must stay well below a quarter of the core clock for both phases to be seen.
	always_comb begin
		sclk_rise = sclk_sync & ~sclk_prev & ~sel_sync; // [R1] [R7]
		sclk_fall = ~sclk_sync & sclk_prev & ~sel_sync; // [R1] [R7] [R11]
	end

	// Select state: a word group is only open while select stays low.
	always_comb begin
		if (sel_sync) begin
			next_state = SCP_IDLE;
		end else begin
			next_state = SCP_SHIFT;
		end
	end

	// Bit counter and input shifter.
	always_comb begin
		next_count = count;
		next_shift = shift;
		word_done = 1'b0;
		// A fresh select pulse always opens a new word, whatever a cut word left behind.
		if (sel_sync || (state == SCP_IDLE && !sclk_rise)) begin
			next_count = 5'h00; // [R4] [R5] [R19]
		end
		if (sel_sync) begin
			next_count = 5'h00;
		end else if (sclk_rise) begin
			next_shift = {shift[21:0], sdi_sync}; // [R2] [R18]
			if (count == `SCP_COUNT_LAST) begin
				next_count = 5'h00; // [R5]
				word_done = 1'b1; // [R3]
			end else begin
				next_count = count + 5'h01;
			end
		end
	end

	// The completed word: address first, then data, most significant bit leading.
	always_comb begin
		word_addr = shift[22:15]; // [R6] [R18]
		word_data = {shift[14:0], sdi_sync}; // [R6] [R18]
	end

	// Register loads, soft reset and readback enable.
	always_comb begin
		next_readback_enabled = readback_enabled;
		next_cfg_wr_valid = 1'b0;
		next_cfg_wr_addr = cfg_wr_addr;
		next_cfg_wr_data = cfg_wr_data;
		mem_clear = rst_sync;
		mem_wr_en = 1'b0;
		mem_wr_addr = word_addr;
		mem_wr_data = word_data;
		if (rst_sync) begin
			next_readback_enabled = 1'b0; // [R17]
		end else if (word_done) begin
			if (word_addr == `SCP_REG_CTRL) begin
				// The control register stays writable in readback mode.
				if (word_data[`SCP_CTRL_SOFT_RESET]) begin
					// The soft reset bit is never stored, so it reads back as zero.
					mem_clear = 1'b1; // [R16] [R17]
					next_readback_enabled = 1'b0; // [R16]
				end else begin
					mem_wr_en = 1'b1; // [R13]
					next_readback_enabled = word_data[`SCP_CTRL_READBACK]; // [R13] [R14]
				end
				next_cfg_wr_valid = 1'b1;
				next_cfg_wr_addr = word_addr;
				next_cfg_wr_data = word_data;
				next_cfg_wr_data[`SCP_CTRL_SOFT_RESET] = 1'b0; // [R16]
			end else if (!readback_enabled) begin
				mem_wr_en = 1'b1; // [R3]
				next_cfg_wr_valid = 1'b1;
				next_cfg_wr_addr = word_addr;
				next_cfg_wr_data = word_data;
			end
			// With readback enabled other addresses are read requests and store nothing.
		end
	end

	// The read is issued as soon as the eighth address bit arrives, ahead of the first
	// falling edge of the data phase.
	always_comb begin
		mem_rd_addr = {shift[6:0], sdi_sync}; // [R10]
		next_rd_pending = sclk_rise && count == `SCP_COUNT_ADDR_LAST && readback_enabled;
	end

	// Readback shifter: one bit per falling edge through the sixteen data clocks.
	always_comb begin
		next_out_shift = out_shift;
		next_shift_data_out = shift_data_out;
		if (sel_sync) begin
			next_shift_data_out = 1'b0;
		end else if (rd_pending) begin
			next_out_shift = mem_rd_data; // [R10]
		end else if (sclk_fall && readback_enabled && count >= `SCP_COUNT_DATA_FIRST) begin
			next_shift_data_out = out_shift[15]; // [R10] [R11] [R18]
			next_out_shift = {out_shift[14:0], 1'b0};
		end
		next_shift_data_out_oe_n = ~next_readback_enabled; // [R15]
	end

	// Word assembly state.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= SCP_IDLE;
			count <= 5'h00;
			shift <= 23'h000000;
		end else begin
			state <= next_state;
			count <= next_count;
			shift <= next_shift;
		end
	end

	// Control state and the load report; the report holds its last word between pulses.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			readback_enabled <= 1'b0;
			cfg_wr_valid <= 1'b0;
			cfg_wr_addr <= 8'h00;
			cfg_wr_data <= `SCP_RESET_VALUE;
		end else begin
			readback_enabled <= next_readback_enabled;
			cfg_wr_valid <= next_cfg_wr_valid;
			cfg_wr_addr <= next_cfg_wr_addr;
			cfg_wr_data <= next_cfg_wr_data;
		end
	end

	// Readback output state. The driver comes out of reset released so a shared line
	// is never fought over while the host is still setting up.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rd_pending <= 1'b0;
			out_shift <= `SCP_RESET_VALUE;
			shift_data_out <= 1'b0;
			shift_data_out_oe_n <= 1'b1;
		end else begin
			rd_pending <= next_rd_pending;
			out_shift <= next_out_shift;
			shift_data_out <= next_shift_data_out;
			shift_data_out_oe_n <= next_shift_data_out_oe_n;
		end
	end

endmodule

// >>> verif/scp_port_checker.sv
// Timing assertions on the outputs of the serial configuration port.
`timescale 1ns/1ps
module scp_port_checker import scp_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hw_reset,
	input wire logic port_select_n,
	input wire logic shift_data_out,
	input wire logic shift_data_out_oe_n,
	input wire logic readback_enabled,
	input wire logic cfg_wr_valid,
	input wire scp_addr_t cfg_wr_addr,
	input wire scp_data_t cfg_wr_data
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	sequence wr_ctrl_s;
		cfg_wr_valid && cfg_wr_addr == 8'h00;
	endsequence
	sequence quiet_s;
		!cfg_wr_valid && !hw_reset;
	endsequence
	oe_on_a: assert property (readback_enabled [*2] |-> !shift_data_out_oe_n)
		else $error("driver off in readback");
	oe_off_a: assert property (!readback_enabled [*2] |-> shift_data_out_oe_n)
		else $error("driver on outside readback");
	pulse_gap_a: assert property ($rose(cfg_wr_valid) |=> !cfg_wr_valid [*8])
		else $error("load pulses too close");
	idle_out_a: assert property (port_select_n [*4] |-> !shift_data_out)
		else $error("output active while idle");
	idle_write_a: assert property (port_select_n [*8] |-> !cfg_wr_valid)
		else $error("load while idle");
	soft_clear_a: assert property (wr_ctrl_s |-> !cfg_wr_data[0])
		else $error("reset bit not cleared");
	rb_follow_a: assert property (wr_ctrl_s |-> ##[0:2] readback_enabled == cfg_wr_data[1])
		else $error("readback bit not taken");
	rb_hold_a: assert property (quiet_s [*5] |-> $stable(readback_enabled))
		else $error("readback bit moved");
	rb_no_write_a: assert property (cfg_wr_valid && readback_enabled |-> wr_ctrl_s)
		else $error("write stored in readback");
endmodule

// >>> verif/scp_host_model.sv
// Host controller model that drives the serial link and gathers readback bits.
`timescale 1ns/1ps
module scp_host_model (
	output logic port_select_n,
	output logic shift_clk,
	output logic shift_data_in,
	input wire logic shift_data_out,
	input wire logic shift_data_out_oe_n
);
	logic [15:0] rd;
	// High time of the shift clock in ns; the period stays 400 ns whatever it is.
	int high_time = 200;
	// The shared line has no pull-up, so a released line shows a changing level.
	wire line_v = shift_data_out_oe_n ? !rd[0] : shift_data_out;
	initial begin
		port_select_n = 1'b1;
		shift_clk = 1'b0;
		shift_data_in = 1'b0;
		rd = 16'h0000;
	end
	task automatic tick(input logic b);
		shift_data_in = b;
		#(400 - high_time);
		shift_clk = 1'b1;
		#(high_time);
		shift_clk = 1'b0;
	endtask
	task automatic open();
		port_select_n = 1'b0;
		#200;
	endtask
	// Capture on the falling edge after each rise keeps clear of the output delay.
	task automatic word(input logic [23:0] w);
		for (int i = 0; i < 24; i++) begin
			tick(w[23 - i]);
			if (i >= 8) rd = {rd[14:0], line_v};
		end
	endtask
	task automatic part(input logic [11:0] p);
		for (int i = 0; i < 12; i++) tick(p[11 - i]);
	endtask
	task automatic close();
		#400;
		port_select_n = 1'b1;
		shift_data_in = 1'b0;
		#400;
	endtask
endmodule

// >>> verif/test_serial_config_port_readback.sv
// Self-checking bench of the serial configuration port.
`timescale 1ns/1ps
module test_serial_config_port_readback import scp_pkg::*;;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic hw_reset = 1'b0;
	wire port_select_n, shift_clk, shift_data_in, shift_data_out, shift_data_out_oe_n;
	wire readback_enabled, cfg_wr_valid;
	scp_addr_t cfg_wr_addr, last_a;
	scp_data_t cfg_wr_data, last_d;
	int bad_count = 0;
	int tests_run = 0;
	int wr_n = 0;
	int n0;
	initial forever #25 core_clk = !core_clk;
	scp_port i_dut(.core_clk, .resetn, .hw_reset, .port_select_n, .shift_clk,
		.shift_data_in, .shift_data_out, .shift_data_out_oe_n, .readback_enabled,
		.cfg_wr_valid, .cfg_wr_addr, .cfg_wr_data);
	scp_host_model i_host(.port_select_n, .shift_clk, .shift_data_in, .shift_data_out,
		.shift_data_out_oe_n);
	always @(posedge core_clk) begin
		if (cfg_wr_valid === 1'b1) begin
			wr_n++;
			last_a = cfg_wr_addr;
			last_d = cfg_wr_data;
		end
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input scp_addr_t a, input scp_data_t d);
		i_host.open();
		i_host.word({a, d});
		i_host.close();
	endtask
	task automatic t_write();
		n0 = wr_n;
		wr(8'h5a, 16'ha5c3);
		chk(24'(wr_n - n0), 24'h000001);
		chk({last_a, last_d}, 24'h5aa5c3);
		chk(shift_data_out_oe_n, 1'b1);
		i_host.high_time = 150;
		wr(8'h66, 16'h1357);
		i_host.high_time = 200;
		chk({last_a, last_d}, 24'h661357);
		$display("write test done");
	endtask
	task automatic t_multi();
		n0 = wr_n;
		i_host.open();
		i_host.word(24'h111234);
		i_host.word(24'h225678);
		i_host.part(12'hfff);
		i_host.close();
		chk(24'(wr_n - n0), 24'h000002);
		chk({last_a, last_d}, 24'h225678);
		i_host.open();
		i_host.part(12'h3c0);
		i_host.close();
		wr(8'h33, 16'h0f0f);
		chk(24'(wr_n - n0), 24'h000003);
		chk({last_a, last_d}, 24'h330f0f);
		$display("multi test done");
	endtask
	task automatic t_read();
		wr(8'h00, 16'h0002);
		chk({shift_data_out_oe_n, readback_enabled}, 2'b01);
		wr(8'h5a, 16'h0000);
		chk(i_host.rd, 16'ha5c3);
		n0 = wr_n;
		wr(8'h5a, 16'hffff);
		chk(24'(wr_n - n0), 24'h000000);
		wr(8'h33, 16'h0000);
		chk(i_host.rd, 16'h0f0f);
		wr(8'h00, 16'h0000);
		chk({shift_data_out_oe_n, readback_enabled}, 2'b10);
		$display("readback test done");
	endtask
	task automatic t_reset();
		wr(8'h00, 16'h0001);
		chk(last_d, 16'h0000);
		wr(8'h00, 16'h0002);
		wr(8'h5a, 16'h0000);
		chk(i_host.rd, 16'h0000);
		wr(8'h00, 16'h0000);
		wr(8'h44, 16'h00ff);
		wr(8'h00, 16'h0002);
		repeat (2) @(negedge core_clk);
		hw_reset = 1'b1;
		repeat (4) @(negedge core_clk);
		hw_reset = 1'b0;
		repeat (4) @(negedge core_clk);
		chk({shift_data_out_oe_n, readback_enabled}, 2'b10);
		wr(8'h00, 16'h0002);
		wr(8'h44, 16'h0000);
		chk(i_host.rd, 16'h0000);
		$display("reset test done");
	endtask
	initial begin
		#2000000;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		t_write();
		t_multi();
		t_read();
		t_reset();
		end_sim();
	end
endmodule
bind scp_port scp_port_checker i_chk(.core_clk, .resetn, .hw_reset, .port_select_n,
	.shift_data_out, .shift_data_out_oe_n, .readback_enabled, .cfg_wr_valid,
	.cfg_wr_addr, .cfg_wr_data);
